// ### hdl/dsl_link_top.sv
`timescale 1ns/100ps
module dsl_link_top #(
  parameter int unsigned TICK_CYCLES = dsl_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // serial line
  input wire logic rxd_i,
  output logic txd_o,
  // configuration
  input dsl_pkg::dsl_cfg_s cfg_i,
  input wire logic [15:0] baud_div_i,
  input wire logic [4:0] station_i,
  input wire logic [13:0] reply_delay_setting_i,
  input wire logic [13:0] link_watchdog_interval_i,
  input wire logic [13:0] retry_limit_setting_i,
  input wire logic [2:0] write_data_chars_i,
  // drive side
  input wire logic coast_stop_input_i,
  input wire logic alarm_reset_i,
  input wire logic [15:0] rd_data_i,
  output dsl_pkg::dsl_cmd_s cmd_o,
  output logic cmd_valid_o,
  output logic run_permit_o,
  output logic coast_o,
  output logic link_timeout_alarm_o,
  output logic retry_alarm_o
);
  import dsl_pkg::*;

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      return {1'b1, c[3:0]};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      return {1'b1, c[3:0] + 4'h9};
    end
    return 5'h00;
  endfunction

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  // tick of 1 ms for reply delay and watchdog
  logic [31:0] tick_cnt_r;
  logic tick;
  assign tick = (tick_cnt_r == TICK_CYCLES - 1);
  always_ff @(posedge mclk_i) begin
    if (rst_i || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // receiver
  logic [1:0] rx_sync_r;
  logic rx_busy_r, rx_done_r;
  logic [15:0] rx_cnt_r;
  logic [3:0] rx_idx_r;
  logic [11:0] rx_frm_r;
  logic [3:0] dlen, rx_last;
  logic [7:0] rx_char;
  logic rx_par, rx_ferr, rx_perr;
  assign dlen = cfg_i.data7 ? 4'h7 : 4'h8;
  assign rx_last = 4'h1 + dlen + {3'h0, cfg_i.parity_en};
  assign rx_char = {cfg_i.data7 ? 1'b0 : rx_frm_r[8], rx_frm_r[7:1]};
  assign rx_par = rx_frm_r[dlen + 4'h1];
  assign rx_ferr = rx_frm_r[0] | ~rx_frm_r[rx_last];
  assign rx_perr = cfg_i.parity_en & ((^rx_char ^ rx_par) != cfg_i.parity_odd);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_sync_r <= SYNC_IDLE;
    end else begin
      rx_sync_r <= {rx_sync_r[0], rxd_i};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_busy_r <= 1'b0;
      rx_done_r <= 1'b0;
      rx_cnt_r <= '0;
      rx_idx_r <= '0;
      rx_frm_r <= '0;
    end else begin
      rx_done_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!rx_sync_r[1]) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r <= {1'b0, baud_div_i[15:1]};
          rx_idx_r <= '0;
        end
      end else if (rx_cnt_r == 16'h0) begin
        rx_frm_r[rx_idx_r] <= rx_sync_r[1];
        rx_cnt_r <= baud_div_i - 16'h1;
        if (rx_idx_r == rx_last) begin
          rx_busy_r <= 1'b0;
          rx_done_r <= 1'b1;
        end else begin
          rx_idx_r <= rx_idx_r + 4'h1;
        end
      end else begin
        rx_cnt_r <= rx_cnt_r - 16'h1;
      end
    end
  end

  // request parser
  typedef enum logic {P_IDLE, P_RECV} dsl_parse_e;
  dsl_parse_e p_state_r;
  logic [4:0] pos_r;
  logic [7:0] sum_r, st_r, ins_r, cks_r;
  logic [3:0] wait_r, code_r;
  logic [23:0] dat_r;
  logic req_done_r;
  logic host_wait;
  logic [4:0] off_d, off_s, off_t, n_term, last_pos;
  logic [4:0] hv;
  logic hex_bad, term_bad;
  assign host_wait = (reply_delay_setting_i == SET_SPECIAL);
  assign off_d = OFS_WAIT + {4'h0, host_wait};
  assign off_s = off_d + (ins_r[7] ? {2'h0, write_data_chars_i} : 5'h0);
  assign off_t = off_s + SUM_CHARS;
  assign n_term = (cfg_i.term_sel == TERM_CR) ? 5'h1 : (cfg_i.term_sel == TERM_CRLF) ? 5'h2 : 5'h0;
  assign last_pos = off_t + n_term - 5'h1;
  assign hv = hex_val(rx_char);
  assign hex_bad = (pos_r < off_t) && !hv[4];
  assign term_bad = (pos_r >= off_t) && (rx_char != ((pos_r == off_t) ? CH_CR : CH_LF));

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      p_state_r <= P_IDLE;
      pos_r <= '0;
      sum_r <= '0;
      st_r <= '0;
      ins_r <= '0;
      cks_r <= '0;
      wait_r <= '0;
      dat_r <= '0;
      code_r <= ERR_NONE;
      req_done_r <= 1'b0;
    end else begin
      req_done_r <= 1'b0;
      if (rx_done_r) begin
        if (rx_char == CH_ENQ && !rx_ferr && !rx_perr) begin
          p_state_r <= P_RECV;
          pos_r <= '0;
          sum_r <= '0;
          dat_r <= '0;
          wait_r <= '0;
          code_r <= ERR_NONE;
        end else if (p_state_r == P_RECV) begin
          pos_r <= pos_r + 5'h1;
          if (code_r == ERR_NONE) begin
            if (rx_ferr) begin
              code_r <= ERR_FRAME;
            end else if (rx_perr) begin
              code_r <= ERR_PARITY;
            end else if (hex_bad) begin
              code_r <= ERR_CHAR;
            end else if (term_bad) begin
              code_r <= ERR_TERM;
            end
          end
          if (pos_r < off_s) begin
            sum_r <= sum_r + rx_char;
          end
          if (pos_r < OFS_INSTR) begin
            st_r <= {st_r[3:0], hv[3:0]};
          end else if (pos_r < OFS_WAIT) begin
            ins_r <= {ins_r[3:0], hv[3:0]};
          end else if (pos_r < off_d) begin
            wait_r <= hv[3:0];
          end else if (pos_r < off_s) begin
            dat_r <= {dat_r[19:0], hv[3:0]};
          end else if (pos_r < off_t) begin
            cks_r <= {cks_r[3:0], hv[3:0]};
          end
          if (pos_r == last_pos) begin
            p_state_r <= P_IDLE;
            req_done_r <= 1'b1;
          end
        end
      end
    end
  end

  // request evaluation
  logic own, good, is_read;
  logic [3:0] err_code;
  assign own = req_done_r && (st_r == {3'h0, station_i});
  assign good = (code_r == ERR_NONE) && (cks_r == sum_r);
  assign err_code = (code_r != ERR_NONE) ? code_r : ERR_SUM;
  assign is_read = !ins_r[7];

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cmd_o <= '0;
      cmd_valid_o <= 1'b0;
    end else begin
      cmd_valid_o <= own && good;
      if (own && good) begin
        cmd_o <= '{instr: ins_r, data: dat_r};
      end
    end
  end

  // reply builder
  logic [7:0] rb_nxt [0:11];
  logic [3:0] rlen_nxt;
  logic [7:0] rsum;
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      rb_nxt[i] = 8'h00;
    end
    rsum = 8'h00;
    rb_nxt[1] = hex_chr(st_r[7:4]);
    rb_nxt[2] = hex_chr(st_r[3:0]);
    if (!good) begin
      rb_nxt[0] = CH_NAK;
      rb_nxt[3] = hex_chr(err_code);
      rlen_nxt = 4'h4;
    end else if (is_read) begin
      rb_nxt[0] = CH_STX;
      for (int i = 0; i < 4; i++) begin
        rb_nxt[3 + i] = hex_chr(rd_data_i[15 - 4 * i -: 4]);
      end
      for (int i = 1; i < 7; i++) begin
        rsum = rsum + rb_nxt[i];
      end
      rb_nxt[7] = CH_ETX;
      rb_nxt[8] = hex_chr(rsum[7:4]);
      rb_nxt[9] = hex_chr(rsum[3:0]);
      rlen_nxt = 4'ha;
    end else begin
      rb_nxt[0] = CH_ACK;
      rlen_nxt = 4'h3;
    end
    if (n_term != 5'h0) begin
      rb_nxt[rlen_nxt] = CH_CR;
    end
    if (n_term == 5'h2) begin
      rb_nxt[rlen_nxt + 4'h1] = CH_LF;
    end
    rlen_nxt = rlen_nxt + n_term[3:0];
  end

  // reply sequencer and transmitter
  typedef enum logic [1:0] {T_IDLE, T_WAIT, T_SEND} dsl_tx_e;
  dsl_tx_e t_state_r;
  logic [7:0] rb_r [0:11];
  logic [3:0] rlen_r, ridx_r;
  logic [7:0] ms_left_r;
  logic tx_busy_r, tx_go;
  logic [11:0] tx_sh_r;
  logic [3:0] tx_n_r;
  logic [15:0] tx_cnt_r;
  logic [7:0] tc;
  assign tx_go = (t_state_r == T_SEND) && !tx_busy_r;
  assign tc = rb_r[ridx_r];

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      t_state_r <= T_IDLE;
      rlen_r <= '0;
      ridx_r <= '0;
      ms_left_r <= '0;
      for (int i = 0; i < 12; i++) begin
        rb_r[i] <= 8'h00;
      end
    end else begin
      case (t_state_r)
        T_IDLE: begin
          if (own) begin
            rb_r <= rb_nxt;
            rlen_r <= rlen_nxt;
            ridx_r <= '0;
            ms_left_r <= host_wait ? ({4'h0, wait_r} * DELAY_STEP_MS) : reply_delay_setting_i[7:0];
            t_state_r <= T_WAIT;
          end
        end
        T_WAIT: begin
          if (ms_left_r == 8'h0) begin
            t_state_r <= T_SEND;
          end else if (tick) begin
            ms_left_r <= ms_left_r - 8'h1;
          end
        end
        T_SEND: begin
          if (tx_go) begin
            if (ridx_r == rlen_r - 4'h1) begin
              t_state_r <= T_IDLE;
            end
            ridx_r <= ridx_r + 4'h1;
          end
        end
        default: t_state_r <= T_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_busy_r <= 1'b0;
      tx_sh_r <= TX_IDLE_LINE;
      tx_n_r <= '0;
      tx_cnt_r <= '0;
    end else if (tx_go) begin
      tx_sh_r <= TX_IDLE_LINE;
      tx_sh_r[0] <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (i < int'(dlen)) begin
          tx_sh_r[i + 1] <= tc[i];
        end
      end
      if (cfg_i.parity_en) begin
        tx_sh_r[dlen + 4'h1] <= ^tc[6:0] ^ (tc[7] & ~cfg_i.data7) ^ cfg_i.parity_odd;
      end
      tx_n_r <= rx_last + {3'h0, cfg_i.stop2};
      tx_cnt_r <= baud_div_i - 16'h1;
      tx_busy_r <= 1'b1;
    end else if (tx_busy_r) begin
      if (tx_cnt_r == 16'h0) begin
        tx_sh_r <= {1'b1, tx_sh_r[11:1]};
        tx_cnt_r <= baud_div_i - 16'h1;
        if (tx_n_r == 4'h0) begin
          tx_busy_r <= 1'b0;
        end else begin
          tx_n_r <= tx_n_r - 4'h1;
        end
      end else begin
        tx_cnt_r <= tx_cnt_r - 16'h1;
      end
    end
  end
  assign txd_o = tx_sh_r[0];

  // link watchdog
  logic [23:0] wd_ms_r;
  logic wd_armed_r;
  logic wd_set, wd_susp, wd_due;
  assign wd_set = (link_watchdog_interval_i != WD_UNSET);
  assign wd_susp = (link_watchdog_interval_i == SET_SPECIAL);
  // interval expired on this tick; a good request in the same cycle re-arms instead
  assign wd_due = tick && wd_armed_r && wd_set && !wd_susp && !(own && good) &&
    (wd_ms_r >= 24'(link_watchdog_interval_i) * WD_MS_PER_UNIT);
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wd_ms_r <= '0;
      wd_armed_r <= 1'b0;
      link_timeout_alarm_o <= 1'b0;
    end else begin
      if (own && good) begin
        wd_ms_r <= '0;
        wd_armed_r <= 1'b1;
      end else if (tick && wd_armed_r && wd_set && !wd_susp && !wd_due) begin
        wd_ms_r <= wd_ms_r + 24'h1;
      end
      // set wins over a clear in the same cycle
      if (wd_due) begin
        link_timeout_alarm_o <= 1'b1;
      end else if (alarm_reset_i) begin
        link_timeout_alarm_o <= 1'b0;
      end
    end
  end

  // consecutive error counter
  logic [13:0] err_cnt_r;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      err_cnt_r <= '0;
      retry_alarm_o <= 1'b0;
    end else begin
      if (own && !good) begin
        err_cnt_r <= err_cnt_r + 14'h1;
      end else if (own && good) begin
        err_cnt_r <= '0;
      end
      // set wins over a clear in the same cycle
      if (own && !good && retry_limit_setting_i != SET_SPECIAL && err_cnt_r + 14'h1 >= retry_limit_setting_i) begin
        retry_alarm_o <= 1'b1;
      end else if (alarm_reset_i) begin
        retry_alarm_o <= 1'b0;
      end
    end
  end

  // coast stop and run interlock
  logic [1:0] coast_sync_r;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      coast_sync_r <= '0;
      coast_o <= 1'b0;
      run_permit_o <= 1'b0;
    end else begin
      coast_sync_r <= {coast_sync_r[0], coast_stop_input_i};
      coast_o <= coast_sync_r[1] | link_timeout_alarm_o | retry_alarm_o;
      run_permit_o <= wd_set & ~coast_sync_r[1] & ~link_timeout_alarm_o & ~retry_alarm_o;
    end
  end
endmodule

// ### hdl/dsl_pkg.sv
package dsl_pkg;
  // control characters
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_NAK = 8'h15;
  // terminator select
  localparam logic [1:0] TERM_NONE = 2'h0;
  localparam logic [1:0] TERM_CR = 2'h1;
  localparam logic [1:0] TERM_CRLF = 2'h2;
  // special setting values
  localparam logic [13:0] SET_SPECIAL = 14'h270f;
  localparam logic [13:0] WD_UNSET = 14'h0000;
  // error codes sent after a negative acknowledge
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_SUM = 4'h1;
  localparam logic [3:0] ERR_PARITY = 4'h2;
  localparam logic [3:0] ERR_FRAME = 4'h4;
  localparam logic [3:0] ERR_CHAR = 4'h5;
  localparam logic [3:0] ERR_TERM = 4'h6;
  // request field offsets (characters after the enquiry)
  localparam logic [4:0] OFS_INSTR = 5'h02;
  localparam logic [4:0] OFS_WAIT = 5'h04;
  localparam logic [4:0] SUM_CHARS = 5'h02;
  // timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0] DELAY_STEP_MS = 8'h0a;
  localparam logic [23:0] WD_MS_PER_UNIT = 24'h000064;
  // reset values
  localparam logic [11:0] TX_IDLE_LINE = 12'hfff;
  localparam logic [1:0] SYNC_IDLE = 2'h3;

  typedef struct packed {
    logic data7;
    logic parity_en;
    logic parity_odd;
    logic stop2;
    logic [1:0] term_sel;
  } dsl_cfg_s;

  typedef struct packed {
    logic [7:0] instr;
    logic [23:0] data;
  } dsl_cmd_s;
endpackage

// ### sim/dsl_host_model.sv
`timescale 1ns/100ps
module dsl_host_model #(
  parameter int DIV = 4
) (
  input wire logic mclk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  logic [7:0] got_q[$];
  logic [7:0] rx_b;
  initial rxd_o = 1'b1;
  // one character, stop bit low when bad
  task automatic put(input logic [7:0] b, input logic bad);
    logic [9:0] f;
    f = {~bad, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o = f[i];
      repeat (DIV) @(negedge mclk_i);
    end
    if (bad) begin
      rxd_o = 1'b1;
      repeat (2 * DIV) @(negedge mclk_i);
    end
  endtask
  // collect reply characters
  initial begin
    forever begin
      @(negedge txd_i);
      repeat (DIV / 2) @(negedge mclk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(negedge mclk_i);
        rx_b[i] = txd_i;
      end
      repeat (DIV) @(negedge mclk_i);
      got_q.push_back(rx_b);
    end
  end
endmodule

// ### sim/dsl_link_monitor.sv
`timescale 1ns/100ps
module dsl_link_monitor #(
  parameter int unsigned TICK_CYCLES = 20
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // line
  input wire logic rxd_i,
  input wire logic txd_o,
  // control
  input wire logic [13:0] link_watchdog_interval_i,
  input wire logic coast_stop_input_i,
  input wire logic alarm_reset_i,
  // status
  input wire logic cmd_valid_o,
  input wire logic run_permit_o,
  input wire logic coast_o,
  input wire logic link_timeout_alarm_o,
  input wire logic retry_alarm_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] quiet_r;
  wire logic alarm_any = link_timeout_alarm_o | retry_alarm_o;
  // cycles since the host last drove the line low
  always_ff @(posedge mclk_i) begin
    if (rst_i || !rxd_i) begin
      quiet_r <= 16'h0000;
    end else if (quiet_r != 16'hffff) begin
      quiet_r <= quiet_r + 16'h0001;
    end
  end
  sequence s_pin_held;
    coast_stop_input_i [*2];
  endsequence
  sequence s_alarm_up;
    alarm_any ##1 alarm_any;
  endsequence
  a_coast_from_pin: assert property (s_pin_held |-> ##[0:3] coast_o)
    else $error("coast output missing");
  a_alarm_coasts: assert property (s_alarm_up |-> coast_o && !run_permit_o)
    else $error("alarm without coast");
  a_unset_blocks: assert property ((link_watchdog_interval_i == 14'h0000) [*3] |-> !run_permit_o)
    else $error("run permitted with watchdog unset");
  a_reply_needs_req: assert property ($fell(txd_o) |-> quiet_r < 16'(200 * TICK_CYCLES + 2000))
    else $error("transmit without request");
  a_valid_one_cycle: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("command pulse too long");
  a_timeout_sticky: assert property (link_timeout_alarm_o && !alarm_reset_i |=> link_timeout_alarm_o)
    else $error("timeout alarm dropped");
  a_retry_sticky: assert property (retry_alarm_o && !alarm_reset_i |=> retry_alarm_o)
    else $error("retry alarm dropped");
  a_reset_quiet: assert property ($fell(rst_i) |-> txd_o && !cmd_valid_o && !alarm_any)
    else $error("outputs active after reset");
endmodule

// ### sim/test_dsl_link_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("unexpected %0t mismatch", $time); end end
module test_dsl_link_top;
  import dsl_pkg::*;
  localparam int unsigned TICK = 20;
  typedef logic [7:0] dsl_bq_t[$];
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rxd, txd, cmd_valid, permit, coast, to_alarm, rt_alarm;
  dsl_cfg_s cfg = '{1'b0, 1'b0, 1'b0, 1'b0, TERM_CR};
  logic [13:0] delay_set = 14'h0000;
  logic [13:0] wd_set = 14'h0000;
  logic coast_pin = 1'b0;
  logic [4:0] station = 5'h05;
  logic alarm_clr = 1'b0;
  dsl_cmd_s cmd, last_cmd;
  int fail_count = 0;
  int num_checks = 0;
  int cmd_cnt = 0;
  dsl_link_top #(.TICK_CYCLES(TICK)) u_dsl_link_top (.mclk_i(mclk_i), .rst_i(rst_i), .rxd_i(rxd), .txd_o(txd),
    .cfg_i(cfg), .baud_div_i(16'h0004), .station_i(station), .reply_delay_setting_i(delay_set),
    .link_watchdog_interval_i(wd_set), .retry_limit_setting_i(14'h0002), .write_data_chars_i(3'h4),
    .coast_stop_input_i(coast_pin), .alarm_reset_i(alarm_clr), .rd_data_i(16'hbeef), .cmd_o(cmd),
    .cmd_valid_o(cmd_valid), .run_permit_o(permit), .coast_o(coast), .link_timeout_alarm_o(to_alarm),
    .retry_alarm_o(rt_alarm));
  dsl_host_model #(.DIV(4)) u_dsl_host_model (.mclk_i(mclk_i), .txd_i(txd), .rxd_o(rxd));
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(negedge mclk_i) begin
    if (cmd_valid === 1'b1) begin
      cmd_cnt++;
      last_cmd = cmd;
    end
  end
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  task automatic req(input logic [4:0] st, input logic [7:0] ins, input int bad, input logic [7:0] bump);
    dsl_bq_t c;
    logic [7:0] s;
    c = '{hx({3'h0, st[4]}), hx(st[3:0]), hx(ins[7:4]), hx(ins[3:0])};
    if (ins[7]) c = {c, hx(4'h1), hx(4'h2), hx(4'h3), hx(4'h4)};
    s = bump;
    foreach (c[i]) s = s + c[i];
    c = {c, hx(s[7:4]), hx(s[3:0]), CH_CR};
    repeat (10 * TICK) @(negedge mclk_i);
    u_dsl_host_model.put(CH_ENQ, 1'b0);
    foreach (c[i]) u_dsl_host_model.put(c[i], i == bad);
  endtask
  task automatic expect_reply(input dsl_bq_t e);
    int n;
    n = 0;
    while (u_dsl_host_model.got_q.size() < e.size() && n < 4000) begin
      @(negedge mclk_i);
      n++;
    end
    repeat (100) @(negedge mclk_i);
    `CHK(u_dsl_host_model.got_q.size(), e.size())
    foreach (e[i]) `CHK(u_dsl_host_model.got_q[i], e[i])
    u_dsl_host_model.got_q.delete();
  endtask
  task automatic t_write();
    int k;
    k = cmd_cnt;
    req(5'h05, 8'hfa, -1, 8'h00);
    expect_reply('{CH_ACK, 8'h30, 8'h35, CH_CR});
    `CHK(cmd_cnt, k + 1)
    `CHK(last_cmd, {8'hfa, 24'h001234})
    $display("test write done");
  endtask
  task automatic t_delay(input logic [13:0] d, input int lo, input int hi);
    int n;
    delay_set = d;
    req(5'h05, 8'hfa, -1, 8'h00);
    n = 0;
    while (txd === 1'b1 && n < 1000) begin
      @(negedge mclk_i);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    expect_reply('{CH_ACK, 8'h30, 8'h35, CH_CR});
    $display("test delay done");
  endtask
  task automatic t_read();
    logic [7:0] s;
    s = 8'h30 + 8'h35 + hx(4'hb) + hx(4'he) + hx(4'he) + hx(4'hf);
    req(5'h05, 8'h70, -1, 8'h00);
    expect_reply('{CH_STX, 8'h30, 8'h35, 8'h42, 8'h45, 8'h45, 8'h46, CH_ETX, hx(s[7:4]), hx(s[3:0]), CH_CR});
    $display("test read done");
  endtask
  task automatic t_bad(input logic [3:0] code, input int bad, input logic [7:0] bump, input logic al);
    int k;
    k = cmd_cnt;
    req(5'h05, 8'hfa, bad, bump);
    expect_reply('{CH_NAK, 8'h30, 8'h35, hx(code), CH_CR});
    `CHK(cmd_cnt, k)
    `CHK(rt_alarm, al)
    `CHK(coast, al)
    $display("test bad request done");
  endtask
  task automatic t_clear();
    alarm_clr = 1'b1;
    @(negedge mclk_i);
    alarm_clr = 1'b0;
    repeat (3) @(negedge mclk_i);
    `CHK(rt_alarm, 1'b0)
    `CHK(permit, 1'b1)
    req(5'h05, 8'hfa, -1, 8'h00);
    expect_reply('{CH_ACK, 8'h30, 8'h35, CH_CR});
    $display("test clear done");
  endtask
  task automatic t_other();
    int k;
    k = cmd_cnt;
    req(5'h06, 8'hfa, -1, 8'h00);
    repeat (700) @(negedge mclk_i);
    `CHK(u_dsl_host_model.got_q.size(), 0)
    `CHK(cmd_cnt, k)
    station = 5'h15;
    req(5'h15, 8'hfa, -1, 8'h00);
    expect_reply('{CH_ACK, 8'h31, 8'h35, CH_CR});
    `CHK(cmd_cnt, k + 1)
    station = 5'h05;
    $display("test other station done");
  endtask
  task automatic t_restart();
    int k;
    k = cmd_cnt;
    u_dsl_host_model.put(CH_ENQ, 1'b0);
    u_dsl_host_model.put(8'h30, 1'b0);
    u_dsl_host_model.put(8'h35, 1'b0);
    req(5'h05, 8'hfa, -1, 8'h00);
    expect_reply('{CH_ACK, 8'h30, 8'h35, CH_CR});
    `CHK(cmd_cnt, k + 1)
    $display("test restart done");
  endtask
  task automatic t_coast();
    coast_pin = 1'b1;
    repeat (5) @(negedge mclk_i);
    `CHK({coast, permit}, 2'h2)
    coast_pin = 1'b0;
    repeat (5) @(negedge mclk_i);
    `CHK({coast, permit}, 2'h1)
    $display("test coast done");
  endtask
  task automatic t_watchdog();
    int n;
    n = 0;
    while (to_alarm !== 1'b1 && n < 5000) begin
      @(negedge mclk_i);
      n++;
    end
    `CHK(n > 3000 && n < 4100, 1'b1)
    repeat (3) @(negedge mclk_i);
    `CHK({coast, permit}, 2'h2)
    $display("test watchdog done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (5) @(negedge mclk_i);
    `CHK(permit, 1'b0)
    wd_set = 14'h0002;
    repeat (5) @(negedge mclk_i);
    `CHK(permit, 1'b1)
    t_write();
    t_delay(14'h000a, 180, 215);
    t_delay(14'h0000, 0, 12);
    t_read();
    t_bad(ERR_SUM, -1, 8'h01, 1'b0);
    t_bad(ERR_FRAME, 2, 8'h00, 1'b1);
    t_clear();
    t_other();
    t_restart();
    t_coast();
    t_watchdog();
    close_out();
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    fail_count++;
    close_out();
  end
endmodule
bind dsl_link_top dsl_link_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_dsl_link_monitor (.mclk_i(mclk_i), .rst_i(rst_i),
  .rxd_i(rxd_i), .txd_o(txd_o), .link_watchdog_interval_i(link_watchdog_interval_i),
  .coast_stop_input_i(coast_stop_input_i), .alarm_reset_i(alarm_reset_i), .cmd_valid_o(cmd_valid_o),
  .run_permit_o(run_permit_o), .coast_o(coast_o), .link_timeout_alarm_o(link_timeout_alarm_o),
  .retry_alarm_o(retry_alarm_o));
